// ===== src/dmpas_access_port.sv
// Purpose: access port unit: transfer address, auto-increment, stalling
// Assumes: memory side holds nothing; mem_ack marks accept and completion
// Notes:   one request in flight; ready drops while a transfer is pending
//
// Behaviour
// - transfer address drives data/banked/direct accesses
// - advance only after successful data access
// - banked and direct accesses never advance address
// - step mode: off, single, packed, reserved
// - without packed support, packed reads as off
// - off mode leaves address unchanged
// - single mode adds access byte size
// - word-only port adds four
// - packed mode merges sub-word beats into word
// - packed sub-word issues several beats, advancing each
// - packed halfword: two beats, step two
// - packed byte: four beats, step one
// - incrementer covers at least ten bits
// - width field one means ten-bit wrap
// - larger field gives 9+field bit wrap
// - debugger keeps sequential accesses inside segment
// - memory accesses stall without cycle bound
// - pending transfer held until target accepts
// - ready shown whenever a new request fits
// - request refused while not ready is unseen
// - debugger retries after wait until ok
// - ready returns after stalled transfer completes
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "dmpas_defs.svh"
module dmpas_access_port
    import dmpas_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    dmpas_if.access_end      link,
    output logic             mem_req_ff,
    output logic             mem_write_ff,
    output logic [31:0]      mem_addr_ff,
    output logic [31:0]      mem_wdata_ff,
    output logic [2:0]       mem_size_ff,
    input  wire logic        mem_ack,
    input  wire logic        mem_err,
    input  wire logic [31:0] mem_rdata
);

    // ------------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------------
    typedef enum {
        ST_IDLE,
        ST_XFER
    } dmpas_state_e;

    dmpas_state_e  state_ff;
    dmpas_state_e  nxt_state;
    logic [31:0]   tar_ff;
    logic [1:0]    mode_ff;
    logic [2:0]    size_ff;
    dmpas_kind_e   kind_ff;
    logic          write_ff;
    logic [2:0]    beats_ff;
    logic [31:0]   acc_ff;
    logic [11:0]   step;
    logic [2:0]    beats;
    logic [31:0]   lane_mask;
    logic [31:0]   merged;
    logic [31:0]   tar_next;
    logic [31:0]   start_addr;
    logic [1:0]    csw_mode_in;
    logic          take;
    logic          take_mem;
    logic          beat_ok;
    logic          beat_bad;
    logic          last_beat;
    logic          incr_on;
    logic          packed_on;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    always_comb begin
        case (size_ff)
            `DMPAS_SIZE_BYTE: step = `DMPAS_STEP_BYTE;
            `DMPAS_SIZE_HALF: step = `DMPAS_STEP_HALF;
            default:          step = `DMPAS_STEP_WORD;
        endcase
    end

    // packed splits every size other than word into beats
    assign packed_on = (mode_ff == `DMPAS_MODE_PACKED) && (size_ff != `DMPAS_SIZE_WORD);

    always_comb begin
        if (!packed_on) begin
            beats = `DMPAS_BEATS_ONE;
        end else if (size_ff == `DMPAS_SIZE_BYTE) begin
            beats = `DMPAS_BEATS_BYTE;
        end else begin
            beats = `DMPAS_BEATS_HALF;
        end
    end

    // reserved and off modes never step; banked and direct never step
    assign incr_on = (kind_ff == KIND_DRW)
                  && ((mode_ff == `DMPAS_MODE_SINGLE)
                   || (mode_ff == `DMPAS_MODE_PACKED));

    // low incrementer bits wrap inside their segment, upper bits hold
    assign tar_next = {tar_ff[31:`DMPAS_INC_BITS],
                       tar_ff[`DMPAS_INC_BITS-1:0] + step};

    always_comb begin
        case (link.req_kind)
            KIND_BD:  start_addr = {tar_ff[31:`DMPAS_BD_KEEP_LSB],
                                    link.req_index[1:0], 2'h0};
            KIND_DAR: start_addr = {tar_ff[31:`DMPAS_DAR_KEEP_LSB],
                                    link.req_index, 2'h0};
            default:  start_addr = tar_ff;
        endcase
    end

    always_comb begin
        case (size_ff)
            `DMPAS_SIZE_BYTE: lane_mask = `DMPAS_MASK_BYTE << {mem_addr_ff[1:0], 3'h0};
            `DMPAS_SIZE_HALF: lane_mask = `DMPAS_MASK_HALF << {mem_addr_ff[1], 4'h0};
            default:          lane_mask = `DMPAS_MASK_WORD;
        endcase
    end

    assign merged = acc_ff | (mem_rdata & lane_mask);

    // handshake events
    assign take      = (state_ff == ST_IDLE) && link.req_valid;
    assign take_mem  = take && (link.req_kind == KIND_DRW || link.req_kind == KIND_BD
                             || link.req_kind == KIND_DAR);
    assign beat_bad  = (state_ff == ST_XFER) && (link.abort || (mem_ack && mem_err));
    assign beat_ok   = (state_ff == ST_XFER) && !link.abort && mem_ack && !mem_err;
    assign last_beat = (beats_ff == `DMPAS_BEATS_ONE);

    assign csw_mode_in = link.req_wdata[`DMPAS_CSW_MODE_LSB +: 2];

    // ------------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take_mem) begin
                    nxt_state = ST_XFER;
                end
            end
            ST_XFER: begin
                // no bound on the wait for mem_ack
                if (beat_bad || (beat_ok && last_beat)) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= ST_IDLE;
            link.ap_ready <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            link.ap_ready <= (nxt_state == ST_IDLE);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            kind_ff  <= KIND_TAR;
            write_ff <= 1'b0;
            beats_ff <= `DMPAS_BEATS_ONE;
            acc_ff   <= 32'h0;
        end else if (ce) begin
            if (take_mem) begin
                kind_ff  <= link.req_kind;
                write_ff <= link.req_write;
                beats_ff <= (link.req_kind == KIND_DRW) ? beats : `DMPAS_BEATS_ONE;
                acc_ff   <= 32'h0;
            end else if (beat_ok) begin
                beats_ff <= beats_ff - `DMPAS_BEATS_ONE;
                acc_ff   <= merged;
            end
        end
    end

    // ------------------------------------------------------------------
    // transfer address and control
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            tar_ff <= 32'h0;
        end else if (ce) begin
            if (take && link.req_write && link.req_kind == KIND_TAR) begin
                tar_ff <= link.req_wdata;
            end else if (beat_ok && incr_on) begin
                tar_ff <= tar_next;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_ff <= `DMPAS_MODE_OFF;
            size_ff <= `DMPAS_SIZE_WORD;
        end else if (ce) begin
            if (take && link.req_write && link.req_kind == KIND_CSW) begin
                size_ff <= link.req_wdata[`DMPAS_ACCESS_SIZE_FIELD_LSB +: 3];
                if (csw_mode_in == `DMPAS_MODE_PACKED && !`DMPAS_PACKED_OK) begin
                    mode_ff <= `DMPAS_MODE_OFF;
                end else begin
                    mode_ff <= csw_mode_in;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // memory side
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            mem_req_ff   <= 1'b0;
            mem_write_ff <= 1'b0;
            mem_addr_ff  <= 32'h0;
            mem_wdata_ff <= 32'h0;
            mem_size_ff  <= `DMPAS_SIZE_WORD;
        end else if (ce) begin
            if (take_mem) begin
                mem_req_ff   <= 1'b1;
                mem_write_ff <= link.req_write;
                mem_addr_ff  <= start_addr;
                mem_wdata_ff <= link.req_wdata;
                mem_size_ff  <= size_ff;
            end else if (beat_bad || (beat_ok && last_beat)) begin
                mem_req_ff <= 1'b0;
            end else if (beat_ok) begin
                mem_addr_ff <= tar_next;
            end
            // otherwise the request stands until the target takes it
        end
    end

    // ------------------------------------------------------------------
    // responses
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            link.rsp_valid <= 1'b0;
            link.rsp_err   <= 1'b0;
            link.rsp_rdata <= 32'h0;
        end else if (ce) begin
            link.rsp_valid <= 1'b0;
            link.rsp_err   <= 1'b0;
            if (take && !take_mem) begin
                link.rsp_valid <= 1'b1;
                link.rsp_rdata <= 32'h0;
                if (!link.req_write) begin
                    case (link.req_kind)
                        KIND_TAR: link.rsp_rdata <= tar_ff;
                        KIND_CSW: begin
                            link.rsp_rdata[`DMPAS_ACCESS_SIZE_FIELD_LSB +: 3] <= size_ff;
                            link.rsp_rdata[`DMPAS_CSW_MODE_LSB +: 2] <= mode_ff;
                        end
                        default:  link.rsp_rdata[`DMPAS_CFG_INC_LSB +: 4] <= `DMPAS_INC_FIELD;
                    endcase
                end
            end else if (beat_bad) begin
                link.rsp_valid <= 1'b1;
                link.rsp_err   <= 1'b1;
                link.rsp_rdata <= 32'h0;
            end else if (beat_ok && last_beat) begin
                link.rsp_valid <= 1'b1;
                link.rsp_rdata <= write_ff ? 32'h0 : merged;
            end
        end
    end

endmodule : dmpas_access_port

// ===== src/dmpas_defs.svh
// Purpose: constants shared by both ends of the debug memory port link
// Assumes: 32-bit data, one clock domain
// Notes:   definitions only
`ifndef DMPAS_DEFS_SVH
`define DMPAS_DEFS_SVH

// ----------------------------------------------------------------------
// address step modes
// ----------------------------------------------------------------------
`define DMPAS_MODE_OFF      2'h0
`define DMPAS_MODE_SINGLE   2'h1
`define DMPAS_MODE_PACKED   2'h2

// ----------------------------------------------------------------------
// access sizes
// ----------------------------------------------------------------------
`define DMPAS_SIZE_BYTE     3'h0
`define DMPAS_SIZE_HALF     3'h1
`define DMPAS_SIZE_WORD     3'h2
`define DMPAS_STEP_BYTE     12'h001
`define DMPAS_STEP_HALF     12'h002
`define DMPAS_STEP_WORD     12'h004
`define DMPAS_BEATS_ONE     3'h1
`define DMPAS_BEATS_HALF    3'h2
`define DMPAS_BEATS_BYTE    3'h4
`define DMPAS_MASK_BYTE     32'h0000_00ff
`define DMPAS_MASK_HALF     32'h0000_ffff
`define DMPAS_MASK_WORD     32'hffff_ffff

// ----------------------------------------------------------------------
// implementation options
// ----------------------------------------------------------------------
`define DMPAS_PACKED_OK     1'b1
`define DMPAS_INC_FIELD     4'h3
`define DMPAS_INC_BITS      12

// ----------------------------------------------------------------------
// register images and field positions
// ----------------------------------------------------------------------
`define DMPAS_ACCESS_SIZE_FIELD_LSB  0
`define DMPAS_CSW_MODE_LSB  4
`define DMPAS_CFG_INC_LSB   16
`define DMPAS_BD_IDX_LSB    2
`define DMPAS_DAR_IDX_LSB   2
`define DMPAS_BD_KEEP_LSB   4
`define DMPAS_DAR_KEEP_LSB  10

`endif

// ===== src/dmpas_pkg.sv
// Purpose: types shared by both ends
// Assumes: nothing
// Notes:   constants live in dmpas_defs.svh
package dmpas_pkg;

    // which port register a request targets
    typedef enum logic [2:0] {
        KIND_TAR,
        KIND_CSW,
        KIND_CFG,
        KIND_DRW,
        KIND_BD,
        KIND_DAR
    } dmpas_kind_e;

endpackage : dmpas_pkg

// ===== src/dmpas_if.sv
// Purpose: link between the debug front port and the access port unit
// Assumes: one clock, all signals registered by their driver
// Notes:   no clocking block
`timescale 1ns/1ps
interface dmpas_if;
    import dmpas_pkg::*;

    logic               req_valid;
    logic               req_write;
    dmpas_kind_e        req_kind;
    logic [7:0]         req_index;
    logic [31:0]        req_wdata;
    logic               abort;
    logic               ap_ready;
    logic               rsp_valid;
    logic               rsp_err;
    logic [31:0]        rsp_rdata;

    modport front_end (
        output req_valid,
        output req_write,
        output req_kind,
        output req_index,
        output req_wdata,
        output abort,
        input  ap_ready,
        input  rsp_valid,
        input  rsp_err,
        input  rsp_rdata
    );

    modport access_end (
        input  req_valid,
        input  req_write,
        input  req_kind,
        input  req_index,
        input  req_wdata,
        input  abort,
        output ap_ready,
        output rsp_valid,
        output rsp_err,
        output rsp_rdata
    );

endinterface : dmpas_if

// ===== src/dmpas_front_port.sv
// Purpose: debug front port: forwards requests, answers ok or wait
// Assumes: user holds no request open; each cmd_valid is one attempt
// Notes:   a refused attempt is dropped; the user retries it
`timescale 1ns/1ps
`include "dmpas_defs.svh"
module dmpas_front_port
    import dmpas_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    dmpas_if.front_end       link,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  dmpas_kind_e      cmd_kind,
    input  wire logic [7:0]  cmd_index,
    input  wire logic [31:0] cmd_wdata,
    input  wire logic        cmd_abort,
    output logic             ack_ok_ff,
    output logic             ack_wait_ff,
    output logic             res_valid_ff,
    output logic             res_err_ff,
    output logic [31:0]      res_rdata_ff
);

    logic can_take;

    // ------------------------------------------------------------------
    // capture decision
    // ------------------------------------------------------------------
    // own request still on the link counts as busy: ready lags one cycle
    assign can_take = link.ap_ready && !link.req_valid;

    always_ff @(posedge clk) begin
        if (srst) begin
            link.req_valid <= 1'b0;
            link.req_write <= 1'b0;
            link.req_kind  <= KIND_TAR;
            link.req_index <= 8'h0;
            link.req_wdata <= 32'h0;
            ack_ok_ff      <= 1'b0;
            ack_wait_ff    <= 1'b0;
        end else if (ce) begin
            link.req_valid <= 1'b0;
            ack_ok_ff      <= 1'b0;
            ack_wait_ff    <= 1'b0;
            if (cmd_valid && can_take) begin
                link.req_valid <= 1'b1;
                link.req_write <= cmd_write;
                link.req_kind  <= cmd_kind;
                link.req_index <= cmd_index;
                link.req_wdata <= cmd_wdata;
                ack_ok_ff      <= 1'b1;
            end else if (cmd_valid) begin
                ack_wait_ff <= 1'b1;  // discarded, never forwarded
            end
        end
    end

    // ------------------------------------------------------------------
    // abort and results
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            link.abort <= 1'b0;
        end else if (ce) begin
            link.abort <= cmd_abort;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            res_valid_ff <= 1'b0;
            res_err_ff   <= 1'b0;
            res_rdata_ff <= 32'h0;
        end else if (ce) begin
            res_valid_ff <= link.rsp_valid;
            if (link.rsp_valid) begin
                res_err_ff   <= link.rsp_err;
                res_rdata_ff <= link.rsp_rdata;
            end
        end
    end

endmodule : dmpas_front_port

// ===== tb/dmpas_link_props.sv
// Purpose: link checks between the front port and the access port unit
// Assumes: ce held high, one clock
// Notes:   watches the dmpas_if signals only
`timescale 1ns/1ps
module dmpas_link_props
    import dmpas_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        req_valid,
    input wire logic        req_write,
    input dmpas_kind_e      req_kind,
    input wire logic        abort,
    input wire logic        ap_ready,
    input wire logic        rsp_valid,
    input wire logic        rsp_err,
    input wire logic [31:0] rsp_rdata
);
    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    logic wr_ff;
    logic mem_kind;
    logic reg_kind;

    assign mem_kind = req_kind inside {KIND_DRW, KIND_BD, KIND_DAR};
    assign reg_kind = req_kind inside {KIND_TAR, KIND_CSW, KIND_CFG};

    // direction of the last request taken
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ff <= 1'b0;
        end else if (req_valid && ap_ready) begin
            wr_ff <= req_write;
        end
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_req_ready: assert property (req_valid |-> ap_ready)
        else $error("request sent while not ready");
    chk_req_pulse: assert property (req_valid |=> !req_valid)
        else $error("request longer than one cycle");
    chk_reg_answer: assert property (req_valid && reg_kind |=> rsp_valid && ap_ready)
        else $error("register access not answered next cycle");
    chk_mem_busy: assert property (req_valid && mem_kind |=> !ap_ready)
        else $error("ready kept while memory transfer pending");
    chk_ready_back: assert property (rsp_valid |-> ap_ready)
        else $error("ready missing with the answer");
    chk_ready_cause: assert property (
        $rose(ap_ready) && !$past(srst) && !$past(srst, 2) && !$past(srst, 3) |-> rsp_valid)
        else $error("ready returned without an answer");
    chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer longer than one cycle");
    chk_no_stray: assert property (
        rsp_valid |-> $past(req_valid) || !$past(ap_ready))
        else $error("answer without a request");
    chk_abort_ends: assert property (abort && !ap_ready |-> ##[0:2] rsp_valid)
        else $error("abort did not end the transfer");
    chk_write_zero: assert property (rsp_valid && wr_ff && !rsp_err |-> rsp_rdata == 32'h0)
        else $error("write answered with data");

endmodule : dmpas_link_props

// ===== tb/debug_mem_port_addr_stall_bench.sv
// Purpose: self-checking bench joining front port and access port
// Assumes: memory side modelled here with adjustable stall
// Notes:   memory word is a5a5 beside its own address
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin failures++; \
    $display("BAD %s exp %h got %h", nm, ex, gt); end end
module debug_mem_port_addr_stall_bench;
    import dmpas_pkg::*;

    typedef struct {logic w; dmpas_kind_e k; logic [7:0] i; logic [31:0] v; int b;} dmpas_row_s;

    logic        clk, srst, ce, cmd_valid, cmd_write, cmd_abort, ok, er, err_en;
    logic        ack_ok_ff, ack_wait_ff, res_valid_ff, res_err_ff;
    logic        mem_req_ff, mem_write_ff, mem_ack, mem_err;
    dmpas_kind_e cmd_kind;
    logic [7:0]  cmd_index;
    logic [31:0] cmd_wdata, res_rdata_ff, mem_addr_ff, mem_wdata_ff, mem_rdata, rd;
    logic [2:0]  mem_size_ff;
    int          failures, checks, stall, beats, wcnt;

    // reads carry the expected data in v, writes send v and expect zero
    dmpas_row_s rows [0:26] = '{
        '{0, KIND_TAR, 8'h0, 32'h0, 0}, '{0, KIND_CSW, 8'h0, 32'h02, 0},
        '{0, KIND_CFG, 8'h0, 32'h0003_0000, 0}, '{1, KIND_TAR, 8'h0, 32'h14a4, 0},
        '{1, KIND_CSW, 8'h0, 32'h12, 0}, '{0, KIND_CSW, 8'h0, 32'h12, 0},
        '{0, KIND_DRW, 8'h0, 32'ha5a5_14a4, 1}, '{0, KIND_TAR, 8'h0, 32'h14a8, 0},
        '{0, KIND_BD, 8'h3, 32'ha5a5_14ac, 1}, '{0, KIND_DAR, 8'h5, 32'ha5a5_1414, 1},
        '{0, KIND_TAR, 8'h0, 32'h14a8, 0}, '{1, KIND_CSW, 8'h0, 32'h01, 0},
        '{1, KIND_DRW, 8'h0, 32'h1234, 1}, '{0, KIND_TAR, 8'h0, 32'h14a8, 0},
        '{1, KIND_CSW, 8'h0, 32'h11, 0}, '{1, KIND_DRW, 8'h0, 32'h5678, 1},
        '{0, KIND_TAR, 8'h0, 32'h14aa, 0}, '{1, KIND_TAR, 8'h0, 32'h100, 0},
        '{1, KIND_CSW, 8'h0, 32'h21, 0}, '{0, KIND_DRW, 8'h0, 32'ha5a5_0100, 2},
        '{0, KIND_TAR, 8'h0, 32'h104, 0}, '{1, KIND_CSW, 8'h0, 32'h20, 0},
        '{1, KIND_DRW, 8'h0, 32'hbeef, 4}, '{0, KIND_TAR, 8'h0, 32'h108, 0},
        '{1, KIND_CSW, 8'h0, 32'h12, 0}, '{1, KIND_TAR, 8'h0, 32'h5ffc, 0},
        '{1, KIND_DRW, 8'h0, 32'h9, 1}};

    // ------------------------------------------------------------------
    // design, link and checker
    // ------------------------------------------------------------------
    dmpas_if link_if ();
    dmpas_front_port u_dmpas_front_port (.clk(clk), .srst(srst), .ce(ce), .link(link_if),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_kind(cmd_kind),
        .cmd_index(cmd_index), .cmd_wdata(cmd_wdata), .cmd_abort(cmd_abort),
        .ack_ok_ff(ack_ok_ff), .ack_wait_ff(ack_wait_ff), .res_valid_ff(res_valid_ff),
        .res_err_ff(res_err_ff), .res_rdata_ff(res_rdata_ff));
    dmpas_access_port u_dmpas_access_port (.clk(clk), .srst(srst), .ce(ce), .link(link_if),
        .mem_req_ff(mem_req_ff), .mem_write_ff(mem_write_ff), .mem_addr_ff(mem_addr_ff),
        .mem_wdata_ff(mem_wdata_ff), .mem_size_ff(mem_size_ff), .mem_ack(mem_ack),
        .mem_err(mem_err), .mem_rdata(mem_rdata));
    dmpas_link_props u_dmpas_link_props (.clk(clk), .srst(srst),
        .req_valid(link_if.req_valid), .req_write(link_if.req_write),
        .req_kind(link_if.req_kind), .abort(link_if.abort), .ap_ready(link_if.ap_ready),
        .rsp_valid(link_if.rsp_valid), .rsp_err(link_if.rsp_err),
        .rsp_rdata(link_if.rsp_rdata));

    // ------------------------------------------------------------------
    // clock, memory target, tasks
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // acks each beat after stall waiting cycles
    always @(posedge clk) begin
        if (mem_req_ff && mem_ack) beats <= beats + 1;
        wcnt      <= (mem_req_ff && !mem_ack) ? wcnt + 1 : 0;
        mem_ack   <= mem_req_ff && !mem_ack && wcnt >= stall;
        mem_rdata <= {16'ha5a5, mem_addr_ff[15:2], 2'h0};
        mem_err   <= err_en;
    end

    task automatic issue(input logic w, input dmpas_kind_e k, input logic [7:0] i,
                         input logic [31:0] d, output logic okv);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_kind  <= k;
        cmd_index <= i;
        cmd_wdata <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
        okv = ack_ok_ff;
    endtask : issue

    task automatic get_res();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (res_valid_ff !== 1'b1 && n < 400);
        `CHK("res_valid", 1'b1, res_valid_ff)
        rd = res_rdata_ff;
        er = res_err_ff;
    endtask : get_res

    task automatic run(input logic w, input dmpas_kind_e k, input logic [7:0] i,
                       input logic [31:0] d);
        issue(w, k, i, d, ok);
        `CHK("ack_ok", 1'b1, ok)
        get_res();
    endtask : run

    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (6000) @(posedge clk);
        failures++;
        end_sim();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        {srst, ce} = 2'b11;
        {cmd_valid, cmd_write, cmd_abort, mem_ack, mem_err, err_en} = 6'h0;
        cmd_kind = KIND_TAR;
        cmd_index = 8'h0;
        cmd_wdata = 32'h0;
        mem_rdata = 32'h0;
        {failures, checks, stall, beats, wcnt} = '0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("rst size", 3'h2, mem_size_ff)
        `CHK("rst req", 1'b0, mem_req_ff)
        @(posedge clk);
        srst <= 1'b0;
        $display("reset done");
        foreach (rows[n]) begin
            beats = 0;
            run(rows[n].w, rows[n].k, rows[n].i, rows[n].w ? rows[n].v : 32'h0);
            `CHK("row data", rows[n].w ? 32'h0 : rows[n].v, rd)
            `CHK("row beats", rows[n].b, beats)
        end
        run(1'b0, KIND_TAR, 8'h0, 32'h0);
        `CHK("wrap", 32'h5000, rd)
        $display("rows done");
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_kind  <= KIND_TAR;
        cmd_write <= 1'b1;
        cmd_wdata <= 32'h2000;
        @(posedge clk);
        #1;
        `CHK("first ok", 1'b1, ack_ok_ff)
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
        `CHK("second wait", 1'b1, ack_wait_ff)
        get_res();
        $display("back to back done");
        stall = 30;
        issue(1'b1, KIND_DRW, 8'h0, 32'h1, ok);
        repeat (4) @(posedge clk);
        #1;
        `CHK("held", 1'b1, mem_req_ff)
        `CHK("held write", 1'b1, mem_write_ff)
        `CHK("held wdata", 32'h1, mem_wdata_ff)
        `CHK("held size", 3'h2, mem_size_ff)
        issue(1'b1, KIND_DRW, 8'h0, 32'h2, ok);
        `CHK("busy wait", 1'b0, ok)
        `CHK("held addr", 32'h2000, mem_addr_ff)
        get_res();
        `CHK("stall err", 1'b0, er)
        stall = 0;
        run(1'b1, KIND_DRW, 8'h0, 32'h2);
        $display("stall done");
        err_en = 1'b1;
        run(1'b0, KIND_DRW, 8'h0, 32'h0);
        `CHK("mem err", 1'b1, er)
        err_en = 1'b0;
        stall = 60;
        issue(1'b1, KIND_DRW, 8'h0, 32'h3, ok);
        repeat (6) @(posedge clk);
        cmd_abort <= 1'b1;
        @(posedge clk);
        cmd_abort <= 1'b0;
        get_res();
        `CHK("abort err", 1'b1, er)
        stall = 0;
        run(1'b0, KIND_TAR, 8'h0, 32'h0);
        `CHK("no step", 32'h2008, rd)
        $display("error and abort done");
        end_sim();
    end

endmodule : debug_mem_port_addr_stall_bench
